// [hw/rbv_pkg.sv]
// Shared constants and types for the calendar value register block
package rbv_pkg;

  // ----------------------------------------------------------------
  // Port selects of the CPU byte interface
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_CFG = 3'h0;
  localparam logic [2:0] SEL_ALM_CFG = 3'h1;
  localparam logic [2:0] SEL_VAL_HIGH = 3'h2;
  localparam logic [2:0] SEL_VAL_LOW = 3'h3;
  localparam logic [2:0] SEL_ALM_HIGH = 3'h4;
  localparam logic [2:0] SEL_ALM_LOW = 3'h5;

  // ----------------------------------------------------------------
  // Control field positions and reset values
  // ----------------------------------------------------------------
  localparam int UNLOCK_BIT = 5;
  localparam int PTR_LSB = 0;
  localparam int PTR_MSB = 1;
  localparam logic UNLOCK_RESET = 1'b0;
  localparam logic [1:0] PTR_RESET = 2'h0;
  localparam logic [1:0] PTR_00 = 2'h0;
  localparam logic [1:0] PTR_01 = 2'h1;
  localparam logic [1:0] PTR_10 = 2'h2;
  localparam logic [1:0] PTR_11 = 2'h3;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Stored register indices and implemented-bit masks
  // ----------------------------------------------------------------
  localparam int NUM_REGS = 9;
  localparam logic [3:0] IDX_YEAR = 4'h0;
  localparam logic [3:0] IDX_MONTH = 4'h1;
  localparam logic [3:0] IDX_DAY = 4'h2;
  localparam logic [3:0] IDX_DAY_OF_WEEK_DIGIT = 4'h3;
  localparam logic [3:0] IDX_HOUR = 4'h4;
  localparam logic [3:0] IDX_MINUTE = 4'h5;
  localparam logic [3:0] IDX_SECOND = 4'h6;
  localparam logic [3:0] IDX_ALM_MONTH = 4'h7;
  localparam logic [3:0] IDX_ALM_DAY = 4'h8;
  localparam logic [3:0] IDX_NONE = 4'hF;

  localparam logic [7:0] MASK_YEAR = 8'hFF;
  localparam logic [7:0] MASK_MONTH = 8'h1F;
  localparam logic [7:0] MASK_DAY = 8'h3F;
  localparam logic [7:0] MASK_DAY_OF_WEEK_DIGIT = 8'h07;
  localparam logic [7:0] MASK_HOUR = 8'h3F;
  localparam logic [7:0] MASK_MINUTE = 8'h7F;
  localparam logic [7:0] MASK_SECOND = 8'h7F;
  localparam logic [NUM_REGS-1:0][7:0] REG_MASK = {
    MASK_DAY, MASK_MONTH, MASK_SECOND, MASK_MINUTE, MASK_HOUR,
    MASK_DAY_OF_WEEK_DIGIT, MASK_DAY, MASK_MONTH, MASK_YEAR
  };

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] sel;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } rbv_bus_req_s;

  typedef struct packed {
    logic [7:0] alarm_day_value;
    logic [7:0] alarm_month_value;
    logic [7:0] time_second;
    logic [7:0] time_minute;
    logic [7:0] time_hour;
    logic [7:0] day_of_week;
    logic [7:0] calendar_day;
    logic [7:0] calendar_month;
    logic [7:0] calendar_year;
  } rbv_values_s;

endpackage

// [hw/rbv_window_ptr.sv]
// Two-bit window pointer that loads from software and counts down to zero
`timescale 1ns/1ps
module rbv_window_ptr (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Control
  input wire logic load_i,
  input wire logic [1:0] load_val_i,
  input wire logic step_i,
  // State
  output logic [1:0] ptr_o
);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ptr_o <= rbv_pkg::PTR_RESET;
    end else if (load_i) begin
      ptr_o <= load_val_i;
    end else if (step_i && ptr_o != rbv_pkg::PTR_00) begin
      ptr_o <= ptr_o - 2'h1;
    end
  end

endmodule

// [hw/rbv_value_reg.sv]
// One BCD value byte; unimplemented bits always read zero
`timescale 1ns/1ps
module rbv_value_reg #(
  parameter logic [7:0] MASK = 8'hFF
) (
  // Clock
  input wire logic sys_clk_i,
  // Write port
  input wire logic we_i,
  input wire logic [7:0] wdata_i,
  // Stored value
  output logic [7:0] q_o
);

  logic [7:0] store_q;

  // No reset: contents are undefined after power-on
  always_ff @(posedge sys_clk_i) begin
    if (we_i) begin
      store_q <= wdata_i;
    end
  end

  // Unused bits tied low so they read zero even before the first write
  assign q_o = store_q & MASK;

endmodule

// [hw/rbv_regs.sv]
// Calendar value registers reached through windowed high and low byte ports
//
// How it works
// - reserved slot reads zero, writes ignored
// - year holds two BCD digits, tens high
// - year written only while unlock set
// - month: tens bit 4, units 3-0
// - day: tens bits 5-4, units 3-0
// - weekday single digit in bits 2-0
// - hour: tens bits 5-4, units 3-0
// - minute: tens bits 6-4, units 3-0
// - second: tens bits 6-4, units 3-0
// - calendar and alarm bytes need unlock to write
// - alarm month laid out like month
// - alarm day laid out like day
// - value window writable only when unlocked
// - value pointer selects which byte each window shows
// - high window access decrements pointer, stops at zero
// - alarm pointer selects alarm month and day
`timescale 1ns/1ps
module rbv_regs (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // CPU byte port
  input wire rbv_pkg::rbv_bus_req_s bus_req_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  // Stored values for the counting logic
  output rbv_pkg::rbv_values_s values_o,
  output logic value_write_unlock_o
);

  // ----------------------------------------------------------------
  // Window decode
  // ----------------------------------------------------------------
  // Shared by read and write so both always agree on the target byte
  function automatic logic [3:0] win_index(input logic [2:0] sel, input logic [1:0] vptr,
                                           input logic [1:0] aptr);
    logic [3:0] idx;
    idx = rbv_pkg::IDX_NONE;
    unique case (sel)
      rbv_pkg::SEL_VAL_HIGH: begin
        unique case (vptr)
          rbv_pkg::PTR_00: idx = rbv_pkg::IDX_MINUTE;
          rbv_pkg::PTR_01: idx = rbv_pkg::IDX_DAY_OF_WEEK_DIGIT;
          rbv_pkg::PTR_10: idx = rbv_pkg::IDX_MONTH;
          rbv_pkg::PTR_11: idx = rbv_pkg::IDX_NONE;
        endcase
      end
      rbv_pkg::SEL_VAL_LOW: begin
        unique case (vptr)
          rbv_pkg::PTR_00: idx = rbv_pkg::IDX_SECOND;
          rbv_pkg::PTR_01: idx = rbv_pkg::IDX_HOUR;
          rbv_pkg::PTR_10: idx = rbv_pkg::IDX_DAY;
          rbv_pkg::PTR_11: idx = rbv_pkg::IDX_YEAR;
        endcase
      end
      rbv_pkg::SEL_ALM_HIGH: begin
        // Only the alarm month byte lives here; the others read zero
        if (aptr == rbv_pkg::PTR_10) begin
          idx = rbv_pkg::IDX_ALM_MONTH;
        end
      end
      rbv_pkg::SEL_ALM_LOW: begin
        if (aptr == rbv_pkg::PTR_10) begin
          idx = rbv_pkg::IDX_ALM_DAY;
        end
      end
      default: idx = rbv_pkg::IDX_NONE;
    endcase
    return idx;
  endfunction

  // One-hot write select; reserved and unstored codes pick nothing
  function automatic logic [rbv_pkg::NUM_REGS-1:0] slot_onehot(input logic [3:0] idx);
    logic [rbv_pkg::NUM_REGS-1:0] hot;
    hot = '0;
    for (int i = 0; i < rbv_pkg::NUM_REGS; i++) begin
      if (idx == 4'(i)) begin
        hot[i] = 1'b1;
      end
    end
    return hot;
  endfunction

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  logic unlock_q;
  logic [1:0] value_ptr;
  logic [1:0] alarm_ptr;
  logic [3:0] acc_idx;
  logic [7:0] reg_val [rbv_pkg::NUM_REGS];
  logic [7:0] rd_mux;
  logic [7:0] cfg_byte;
  logic [7:0] alm_cfg_byte;
  logic cfg_wr;
  logic alm_cfg_wr;
  logic val_high_acc;
  logic alm_high_acc;
  logic value_wr;
  logic [rbv_pkg::NUM_REGS-1:0] reg_we;

  // ----------------------------------------------------------------
  // Unlock bit
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      unlock_q <= rbv_pkg::UNLOCK_RESET;
    end else if (cfg_wr) begin
      unlock_q <= bus_req_i.wdata[rbv_pkg::UNLOCK_BIT];
    end
  end

  assign value_write_unlock_o = unlock_q;

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  assign acc_idx = win_index(bus_req_i.sel, value_ptr, alarm_ptr);
  assign cfg_wr = bus_req_i.wr && (bus_req_i.sel == rbv_pkg::SEL_CFG);
  assign alm_cfg_wr = bus_req_i.wr && (bus_req_i.sel == rbv_pkg::SEL_ALM_CFG);
  // Any access moves the pointer, an ignored write included
  assign val_high_acc = (bus_req_i.wr || bus_req_i.rd) && (bus_req_i.sel == rbv_pkg::SEL_VAL_HIGH);
  assign alm_high_acc = (bus_req_i.wr || bus_req_i.rd) && (bus_req_i.sel == rbv_pkg::SEL_ALM_HIGH);
  // Locked writes simply vanish; software gets no error indication
  assign value_wr = bus_req_i.wr && unlock_q;
  assign reg_we = slot_onehot(acc_idx) & {rbv_pkg::NUM_REGS{value_wr}};

  // ----------------------------------------------------------------
  // Window pointers
  // ----------------------------------------------------------------
  rbv_window_ptr u_value_ptr (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .load_i(cfg_wr),
    .load_val_i(bus_req_i.wdata[rbv_pkg::PTR_MSB:rbv_pkg::PTR_LSB]),
    .step_i(val_high_acc),
    .ptr_o(value_ptr)
  );

  // No roll-over mode: the alarm pointer also stops at zero
  rbv_window_ptr u_alarm_ptr (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .load_i(alm_cfg_wr),
    .load_val_i(bus_req_i.wdata[rbv_pkg::PTR_MSB:rbv_pkg::PTR_LSB]),
    .step_i(alm_high_acc),
    .ptr_o(alarm_ptr)
  );

  // ----------------------------------------------------------------
  // Value storage
  // ----------------------------------------------------------------
  // Masks keep unimplemented bits at zero so they always read back zero
  rbv_value_reg #(
    .MASK(rbv_pkg::REG_MASK[rbv_pkg::IDX_YEAR])
  ) u_year (
    .sys_clk_i(sys_clk_i),
    .we_i(reg_we[rbv_pkg::IDX_YEAR]),
    .wdata_i(bus_req_i.wdata),
    .q_o(reg_val[rbv_pkg::IDX_YEAR])
  );

  rbv_value_reg #(
    .MASK(rbv_pkg::REG_MASK[rbv_pkg::IDX_MONTH])
  ) u_month (
    .sys_clk_i(sys_clk_i),
    .we_i(reg_we[rbv_pkg::IDX_MONTH]),
    .wdata_i(bus_req_i.wdata),
    .q_o(reg_val[rbv_pkg::IDX_MONTH])
  );

  rbv_value_reg #(
    .MASK(rbv_pkg::REG_MASK[rbv_pkg::IDX_DAY])
  ) u_day (
    .sys_clk_i(sys_clk_i),
    .we_i(reg_we[rbv_pkg::IDX_DAY]),
    .wdata_i(bus_req_i.wdata),
    .q_o(reg_val[rbv_pkg::IDX_DAY])
  );

  rbv_value_reg #(
    .MASK(rbv_pkg::REG_MASK[rbv_pkg::IDX_DAY_OF_WEEK_DIGIT])
  ) u_day_of_week_digit (
    .sys_clk_i(sys_clk_i),
    .we_i(reg_we[rbv_pkg::IDX_DAY_OF_WEEK_DIGIT]),
    .wdata_i(bus_req_i.wdata),
    .q_o(reg_val[rbv_pkg::IDX_DAY_OF_WEEK_DIGIT])
  );

  rbv_value_reg #(
    .MASK(rbv_pkg::REG_MASK[rbv_pkg::IDX_HOUR])
  ) u_hour (
    .sys_clk_i(sys_clk_i),
    .we_i(reg_we[rbv_pkg::IDX_HOUR]),
    .wdata_i(bus_req_i.wdata),
    .q_o(reg_val[rbv_pkg::IDX_HOUR])
  );

  rbv_value_reg #(
    .MASK(rbv_pkg::REG_MASK[rbv_pkg::IDX_MINUTE])
  ) u_minute (
    .sys_clk_i(sys_clk_i),
    .we_i(reg_we[rbv_pkg::IDX_MINUTE]),
    .wdata_i(bus_req_i.wdata),
    .q_o(reg_val[rbv_pkg::IDX_MINUTE])
  );

  rbv_value_reg #(
    .MASK(rbv_pkg::REG_MASK[rbv_pkg::IDX_SECOND])
  ) u_second (
    .sys_clk_i(sys_clk_i),
    .we_i(reg_we[rbv_pkg::IDX_SECOND]),
    .wdata_i(bus_req_i.wdata),
    .q_o(reg_val[rbv_pkg::IDX_SECOND])
  );

  rbv_value_reg #(
    .MASK(rbv_pkg::REG_MASK[rbv_pkg::IDX_ALM_MONTH])
  ) u_alm_month (
    .sys_clk_i(sys_clk_i),
    .we_i(reg_we[rbv_pkg::IDX_ALM_MONTH]),
    .wdata_i(bus_req_i.wdata),
    .q_o(reg_val[rbv_pkg::IDX_ALM_MONTH])
  );

  rbv_value_reg #(
    .MASK(rbv_pkg::REG_MASK[rbv_pkg::IDX_ALM_DAY])
  ) u_alm_day (
    .sys_clk_i(sys_clk_i),
    .we_i(reg_we[rbv_pkg::IDX_ALM_DAY]),
    .wdata_i(bus_req_i.wdata),
    .q_o(reg_val[rbv_pkg::IDX_ALM_DAY])
  );

  // ----------------------------------------------------------------
  // Stored values out
  // ----------------------------------------------------------------
  assign values_o = '{
    alarm_day_value: reg_val[rbv_pkg::IDX_ALM_DAY],
    alarm_month_value: reg_val[rbv_pkg::IDX_ALM_MONTH],
    time_second: reg_val[rbv_pkg::IDX_SECOND],
    time_minute: reg_val[rbv_pkg::IDX_MINUTE],
    time_hour: reg_val[rbv_pkg::IDX_HOUR],
    day_of_week: reg_val[rbv_pkg::IDX_DAY_OF_WEEK_DIGIT],
    calendar_day: reg_val[rbv_pkg::IDX_DAY],
    calendar_month: reg_val[rbv_pkg::IDX_MONTH],
    calendar_year: reg_val[rbv_pkg::IDX_YEAR]
  };

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unused control bits read zero
  always_comb begin
    cfg_byte = rbv_pkg::READ_ZERO;
    cfg_byte[rbv_pkg::UNLOCK_BIT] = unlock_q;
    cfg_byte[rbv_pkg::PTR_MSB:rbv_pkg::PTR_LSB] = value_ptr;
    alm_cfg_byte = rbv_pkg::READ_ZERO;
    alm_cfg_byte[rbv_pkg::PTR_MSB:rbv_pkg::PTR_LSB] = alarm_ptr;
  end

  always_comb begin
    unique case (bus_req_i.sel)
      rbv_pkg::SEL_CFG: begin
        rd_mux = cfg_byte;
      end
      rbv_pkg::SEL_ALM_CFG: begin
        rd_mux = alm_cfg_byte;
      end
      default: begin
        if (acc_idx == rbv_pkg::IDX_NONE) begin
          rd_mux = rbv_pkg::READ_ZERO;
        end else begin
          rd_mux = reg_val[acc_idx];
        end
      end
    endcase
  end

  // Data is sampled with the pointer as it stood before the decrement
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rd_data_o <= rbv_pkg::READ_ZERO;
    end else if (bus_req_i.rd) begin
      rd_data_o <= rd_mux;
    end
  end

  // Answer strobe comes for every read, unmapped ports included
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= bus_req_i.rd;
    end
  end

endmodule

// [dv/rbv_cpu_mdl.sv]
// CPU byte-port master model for the calendar value registers
`timescale 1ns/1ps
module rbv_cpu_mdl (
  // Clock
  input wire logic sys_clk_i,
  // Request
  output rbv_pkg::rbv_bus_req_s req_o
);
  initial req_o = '0;
  // Called just after an edge; held until the edge that takes it
  task automatic acc(input logic [2:0] s, input logic w, input logic [7:0] d);
    req_o = {s, w, ~w, d};
    @(posedge sys_clk_i);
    #1;
  endtask
  task automatic idle();
    req_o = '0;
  endtask
endmodule

// [dv/rbv_regs_chk.sv]
// Port-level assertions for the calendar value registers
`timescale 1ns/1ps
module rbv_regs_chk (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Watched ports
  input wire rbv_pkg::rbv_bus_req_s bus_req_i,
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire rbv_pkg::rbv_values_s values_o,
  input wire logic value_write_unlock_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  chk_rd_answer: assert property (bus_req_i.rd |=> rd_valid_o)
    else $error("read not answered");
  chk_no_stray: assert property (!bus_req_i.rd |=> !rd_valid_o)
    else $error("stray read valid");
  chk_data_hold: assert property (!bus_req_i.rd |=> $stable(rd_data_o))
    else $error("read data moved");
  chk_unlock_load: assert property ((bus_req_i.wr && bus_req_i.sel == rbv_pkg::SEL_CFG)
    |=> value_write_unlock_o == $past(bus_req_i.wdata[5])) else $error("unlock not loaded");
  chk_unlock_keep: assert property (!(bus_req_i.wr && bus_req_i.sel == rbv_pkg::SEL_CFG)
    |=> $stable(value_write_unlock_o)) else $error("unlock moved");
  chk_locked_write: assert property ((bus_req_i.wr && !value_write_unlock_o
    && bus_req_i.sel inside {[3'h2:3'h5]}) |=> $stable(values_o)) else $error("locked write landed");
  chk_month_bits: assert property (((values_o.calendar_month | values_o.alarm_month_value)
    & 8'hE0) == 8'h00) else $error("month high bits set");
  chk_day_bits: assert property (((values_o.calendar_day | values_o.alarm_day_value
    | values_o.time_hour) & 8'hC0) == 8'h00) else $error("day or hour high bits set");
  chk_short_bits: assert property (((values_o.day_of_week & 8'hF8)
    | ((values_o.time_minute | values_o.time_second) & 8'h80)) == 8'h00) else $error("unused bits set");
endmodule
bind rbv_regs rbv_regs_chk rbv_regs_chk_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .bus_req_i(bus_req_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .values_o(values_o),
  .value_write_unlock_o(value_write_unlock_o));

// [dv/rbv_regs_tb.sv]
// Self-checking bench for the calendar value registers
`timescale 1ns/1ps
module rbv_regs_tb;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  rbv_pkg::rbv_bus_req_s bus_req;
  logic [7:0] rd_data;
  logic rd_valid;
  logic unlock;
  rbv_pkg::rbv_values_s vals;
  int miscompares = 0;
  int check_count = 0;
  int mv[9];
  bit mk[9];
  int vptr = 0;
  int aptr = 0;
  int unl = 0;
  logic [31:0] lfsr = 32'h24057EC8;
  const int MSK[9] = '{8'hFF, 8'h1F, 8'h3F, 8'h07, 8'h3F, 8'h7F, 8'h7F, 8'h1F, 8'h3F};
  const int HI[4] = '{5, 3, 1, -1};
  const int LO[4] = '{6, 4, 2, 0};
  rbv_cpu_mdl rbv_cpu_mdl_inst (.sys_clk_i(sys_clk_i), .req_o(bus_req));
  rbv_regs rbv_regs_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus_req_i(bus_req), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .values_o(vals), .value_write_unlock_o(unlock));
  task automatic test_done();
    if (miscompares == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // Model slot behind each window; -1 reads zero and takes no write
  function automatic int slot(input int s);
    if (s == 2) return HI[vptr];
    if (s == 3) return LO[vptr];
    if (s == 4 && aptr == 2) return 7;
    if (s == 5 && aptr == 2) return 8;
    return -1;
  endfunction
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic op(input logic [2:0] s, input logic w, input logic [7:0] d);
    int k;
    int e;
    k = slot(s);
    e = k < 0 ? 0 : (mk[k] ? mv[k] : -1);
    if (s == 0) e = unl * 32 + vptr;
    if (s == 1) e = aptr;
    if (w && s == 0) begin
      unl = d[5];
      vptr = d[1:0];
    end
    if (w && s == 1) aptr = d[1:0];
    if (w && k >= 0 && unl == 1) begin
      mv[k] = d & MSK[k];
      mk[k] = 1'b1;
    end
    if (s == 2 && vptr > 0) vptr--;
    if (s == 4 && aptr > 0) aptr--;
    rbv_cpu_mdl_inst.acc(s, w, d);
    chk("rd_valid", 8'(rd_valid), 8'(!w));
    if (!w && e >= 0) chk("rd_data", rd_data, e[7:0]);
    chk("unlock", 8'(unlock), unl[7:0]);
    for (int i = 0; i < 9; i++) begin
      if (mk[i]) chk("value", vals[i*8 +: 8], mv[i][7:0]);
    end
  endtask
  initial begin
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  // Whole run is under 500 accesses; this bound is several times that
  initial begin
    #100000;
    miscompares++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge sys_clk_i);
    #1;
    rst_i = 1'b0;
    @(posedge sys_clk_i);
    #1;
    chk("reset unlock", 8'(unlock), 8'h00);
    for (int p = 3; p >= 0; p--) begin
      op(3'h0, 1'b1, 8'(32 + p));
      op(3'h3, 1'b1, lfsr[7:0] + 8'(p));
    end
    op(3'h0, 1'b1, 8'h23);
    repeat (5) op(3'h2, 1'b1, 8'hFF - lfsr[15:8]);
    op(3'h1, 1'b1, 8'h02);
    op(3'h5, 1'b1, 8'hFF);
    op(3'h4, 1'b1, 8'hFF);
    repeat (400) begin
      repeat (16) lfsr = lfsr_next(lfsr);
      op(lfsr[2:0], lfsr[3], lfsr[15:8]);
    end
    rbv_cpu_mdl_inst.idle();
    test_done();
  end
endmodule
